/* File: hdl/dtc_timer.sv */
// Dual four-mode timer/counter with its mode, control and count registers.
//
// Functional notes
// R1 - Timer mode counts once per machine cycle, every twelve clocks.
// R2 - Counter mode counts each falling edge on the unit count input.
// R3 - Edge detection takes two machine cycles, limiting count rate to 1/24.
// R4 - External source holds each count level at least one machine cycle.
// R5 - Mode 0 counts 13 bits: high byte plus low five low-byte bits.
// R6 - Setting a run bit leaves the count bytes unchanged.
// R7 - Wrap from all ones to zero sets the unit overflow flag.
// R8 - Mode 1 is mode 0 with all eight low bits: 16-bit count.
// R9 - Mode 2 low byte counts, reloads from unchanged high byte on overflow.
// R10 - Mode 3 unit A low byte is an 8-bit counter on unit A bits.
// R11 - Mode 3 unit A high byte times cycles, uses unit B run and flag.
// R12 - Unit B in mode 3 stops and holds its count.
// R13 - With unit A in mode 3, unit B starts/stops via mode 3, no flag.
// R14 - Mode register low nibble is unit A, high nibble is unit B.
// R15 - Counter select bit 1 counts edges, 0 counts machine cycles.
// R16 - With gate set, a unit advances only while gate pin high and running.
// R17 - Mode bits 00 13-bit, 01 16-bit, 10 auto-reload, 11 mode 3.
// R18 - Hardware sets overflow flags at control bits 5 and 7; software clears.
// R19 - Run bits at control bits 4 and 6 halt the unit when clear.
// R20 - Unit A low mode bit sits at mode register bit 0.
// R21 - Count inputs sampled once per machine cycle; high then low is an edge.
module dtc_timer
    import dtc_pkg::*;
#(
    parameter int OSC_PER_MCYC = DTC_OSC_PER_MCYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // External pins
    input wire logic count_input_a,
    input wire logic count_input_b,
    input wire logic gate_pin_a,
    input wire logic gate_pin_b,
    // Status
    output logic unit_a_overflow_flag,
    output logic unit_b_overflow_flag,
    output logic mcyc_tick
);

    // Ratios above 16 would not fit the four-bit machine cycle divider; a ratio of 1 is refused as well.
    if (OSC_PER_MCYC < 2 || OSC_PER_MCYC > 16) begin : g_osc_range_bad
        $error("OSC_PER_MCYC must lie in 2..16");
    end

    localparam logic [3:0] MCYC_LAST = 4'(OSC_PER_MCYC - 1);

    // ------------------------------------------------------------
    // Machine cycle divider
    // ------------------------------------------------------------
    logic [3:0] div_q, div_d;
    logic tick;

    always_comb begin
        tick = (div_q == MCYC_LAST);
        if (tick) begin
            div_d = 4'h0; // see R1
        end else begin
            div_d = div_q + 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_d;
        end
    end

    assign mcyc_tick = tick;

    // ------------------------------------------------------------
    // Count input sampling
    // ------------------------------------------------------------
    // One sample per machine cycle: an edge needs a high sample then a low
    // sample, so two machine cycles are the least spacing between counts.
    logic [1:0] samp_q, samp_d, prev_q, prev_d;
    logic [1:0] fall;

    always_comb begin
        samp_d = samp_q;
        prev_d = prev_q;
        if (tick) begin
            samp_d = {count_input_b, count_input_a}; // see R21
            prev_d = samp_q;
        end
        fall = prev_q & ~samp_q; // see R2, R3
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            samp_q <= 2'b00;
            prev_q <= 2'b00;
        end else begin
            samp_q <= samp_d;
            prev_q <= prev_d;
        end
    end

    // The fall term stays true a whole machine cycle; count it once at tick.
    logic [1:0] fall_evt;
    assign fall_evt = fall & {2{tick}};

    // ------------------------------------------------------------
    // Registers and counting
    // ------------------------------------------------------------
    logic [7:0] mode_q, mode_d, ctrl_q, ctrl_d;
    dtc_pair_t a_q, a_d, b_q, b_d;
    dtc_unit_cfg_t cfg_a, cfg_b;
    logic run_a, run_b, en_a, en_b, en_ah;
    logic set_fa, set_fb;
    logic [8:0] sum_al, sum_bl, sum_ah, sum_bh;
    logic wrap_b;

    always_comb begin
        // see R14, R20, R15, R16, R17
        cfg_a = dtc_unit_cfg_t'(mode_q[3:0]);
        cfg_b = dtc_unit_cfg_t'(mode_q[7:DTC_UNIT_B_BASE]);
        run_a = ctrl_q[DTC_C_RUN_A]; // see R19
        run_b = ctrl_q[DTC_C_RUN_B];
        en_a = run_a && (!cfg_a.gate || gate_pin_a) // see R16
            && (cfg_a.counter ? fall_evt[0] : tick); // see R1, R2, R15
        en_b = run_b && (!cfg_b.gate || gate_pin_b)
            && (cfg_b.counter ? fall_evt[1] : tick)
            && (cfg_b.mode != DTC_MODE_SPLIT); // see R12, R13
        // The split high byte has no counter path and no gate of its own.
        en_ah = run_b && tick; // see R11

        a_d = a_q;
        b_d = b_q;
        set_fa = 1'b0;
        set_fb = 1'b0;
        wrap_b = 1'b0;
        sum_al = {1'b0, a_q.low} + 9'h001;
        sum_bl = {1'b0, b_q.low} + 9'h001;
        sum_ah = {1'b0, a_q.high} + 9'h001;
        sum_bh = {1'b0, b_q.high} + 9'h001;

        // Unit A.
        if (en_a) begin
            unique case (cfg_a.mode)
                DTC_MODE_13BIT: begin // see R5
                    // The upper three low-byte bits keep whatever software wrote.
                    if (a_q.low[DTC_M0_LOW_BITS-1:0] == DTC_M0_LOW_MAX[4:0]) begin
                        a_d.low[DTC_M0_LOW_BITS-1:0] = 5'h00;
                        a_d.high = sum_ah[7:0];
                        set_fa = sum_ah[8]; // see R7
                    end else begin
                        a_d.low = sum_al[7:0];
                    end
                end
                DTC_MODE_16BIT: begin // see R8
                    // The high byte advances only on the low byte's carry.
                    a_d.low = sum_al[7:0];
                    if (sum_al[8]) begin
                        a_d.high = sum_ah[7:0];
                        set_fa = sum_ah[8]; // see R7
                    end
                end
                DTC_MODE_RELOAD: begin // see R9
                    // The reload copies the high byte and never writes it.
                    if (sum_al[8]) begin
                        a_d.low = a_q.high;
                    end else begin
                        a_d.low = sum_al[7:0];
                    end
                    set_fa = sum_al[8];
                end
                DTC_MODE_SPLIT: begin // see R10
                    // Unit A's run bit and gate still steer the split low byte.
                    a_d.low = sum_al[7:0];
                    set_fa = sum_al[8];
                end
            endcase
        end
        if (cfg_a.mode == DTC_MODE_SPLIT && en_ah) begin // see R11
            a_d.high = sum_ah[7:0];
            set_fb = sum_ah[8];
        end

        // Unit B; its flag belongs to unit A's high byte while A is split.
        if (en_b) begin
            unique case (cfg_b.mode)
                DTC_MODE_13BIT: begin
                    if (b_q.low[DTC_M0_LOW_BITS-1:0] == DTC_M0_LOW_MAX[4:0]) begin
                        b_d.low[DTC_M0_LOW_BITS-1:0] = 5'h00;
                        b_d.high = sum_bh[7:0];
                        wrap_b = sum_bh[8];
                    end else begin
                        b_d.low = sum_bl[7:0];
                    end
                end
                DTC_MODE_16BIT: begin
                    b_d.low = sum_bl[7:0];
                    if (sum_bl[8]) begin
                        b_d.high = sum_bh[7:0];
                        wrap_b = sum_bh[8];
                    end
                end
                DTC_MODE_RELOAD: begin
                    if (sum_bl[8]) begin
                        b_d.low = b_q.high;
                    end else begin
                        b_d.low = sum_bl[7:0];
                    end
                    wrap_b = sum_bl[8];
                end
                DTC_MODE_SPLIT: begin
                    // The enable already holds a unit parked in mode 3.
                    b_d = b_q; // see R12
                end
            endcase
        end
        // Unit B run beside a split unit A counts but raises no overflow of its own.
        if (wrap_b && cfg_a.mode != DTC_MODE_SPLIT) begin
            set_fb = 1'b1; // see R13
        end

        // Software access; a run-bit write leaves the bytes alone.
        mode_d = mode_q;
        ctrl_d = ctrl_q;
        // A byte write in the same cycle as a count wins; a carry into the other byte lands.
        if (reg_wr) begin
            unique case (reg_addr)
                DTC_ADDR_MODE: mode_d = reg_wdata;
                DTC_ADDR_CTRL: ctrl_d = reg_wdata; // see R6
                DTC_ADDR_A_LOW: a_d.low = reg_wdata;
                DTC_ADDR_A_HIGH: a_d.high = reg_wdata;
                DTC_ADDR_B_LOW: b_d.low = reg_wdata;
                DTC_ADDR_B_HIGH: b_d.high = reg_wdata;
                default: ;
            endcase
        end
        // Hardware set wins over a software clear in the same cycle.
        if (set_fa) begin
            ctrl_d[DTC_C_FLAG_A] = 1'b1; // see R18
        end
        if (set_fb) begin
            ctrl_d[DTC_C_FLAG_B] = 1'b1; // see R18
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode_q <= DTC_RST_MODE;
            ctrl_q <= DTC_RST_CTRL;
            a_q <= {DTC_RST_BYTE, DTC_RST_BYTE};
            b_q <= {DTC_RST_BYTE, DTC_RST_BYTE};
        end else begin
            mode_q <= mode_d;
            ctrl_q <= ctrl_d;
            a_q <= a_d;
            b_q <= b_d;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        // Read data is zero outside the cycle after a read, so idle cycles leak no state.
        rdata_d = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                DTC_ADDR_MODE: rdata_d = mode_q;
                DTC_ADDR_CTRL: rdata_d = ctrl_q;
                DTC_ADDR_A_LOW: rdata_d = a_q.low;
                DTC_ADDR_A_HIGH: rdata_d = a_q.high;
                DTC_ADDR_B_LOW: rdata_d = b_q.low;
                DTC_ADDR_B_HIGH: rdata_d = b_q.high;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign unit_a_overflow_flag = ctrl_q[DTC_C_FLAG_A];
    assign unit_b_overflow_flag = ctrl_q[DTC_C_FLAG_B];

endmodule // dtc_timer

/* File: hdl/dtc_pkg.sv */
// Package of register offsets, field positions, reset values and timing counts.
package dtc_pkg;

    // Register addresses on the plain register port.
    localparam logic [7:0] DTC_ADDR_MODE = 8'h89;
    localparam logic [7:0] DTC_ADDR_CTRL = 8'h88;
    localparam logic [7:0] DTC_ADDR_A_LOW = 8'h8a;
    localparam logic [7:0] DTC_ADDR_B_LOW = 8'h8b;
    localparam logic [7:0] DTC_ADDR_A_HIGH = 8'h8c;
    localparam logic [7:0] DTC_ADDR_B_HIGH = 8'h8d;

    // Reset values.
    localparam logic [7:0] DTC_RST_MODE = 8'h00;
    localparam logic [7:0] DTC_RST_CTRL = 8'h00;
    localparam logic [7:0] DTC_RST_BYTE = 8'h00;

    // Field positions in the mode register, per unit nibble.
    localparam int DTC_UNIT_B_BASE = 4;
    localparam int DTC_F_MODE_LOW = 0;
    localparam int DTC_F_MODE_HIGH = 1;
    localparam int DTC_F_COUNTER = 2;
    localparam int DTC_F_GATE = 3;

    // Field positions in the control register.
    localparam int DTC_C_RUN_A = 4;
    localparam int DTC_C_FLAG_A = 5;
    localparam int DTC_C_RUN_B = 6;
    localparam int DTC_C_FLAG_B = 7;

    // Timing: oscillator periods per machine cycle.
    localparam int DTC_OSC_PER_MCYC = 12;
    localparam logic [3:0] DTC_MCYC_LAST = 4'(DTC_OSC_PER_MCYC - 1);

    // Mode 0 uses this many low-byte bits.
    localparam int DTC_M0_LOW_BITS = 5;
    localparam logic [7:0] DTC_M0_LOW_MAX = 8'h1f;

    typedef enum logic [1:0] {
        DTC_MODE_13BIT,
        DTC_MODE_16BIT,
        DTC_MODE_RELOAD,
        DTC_MODE_SPLIT
    } dtc_mode_t;

    typedef struct packed {
        logic gate;
        logic counter;
        dtc_mode_t mode;
    } dtc_unit_cfg_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } dtc_pair_t;

endpackage : dtc_pkg

/* File: bench/dtc_monitor.sv */
// Checker of the dual timer's machine tick, read port and overflow flags.
module dtc_monitor
    import dtc_pkg::*;
#(
    parameter int OSC_PER_MCYC = DTC_OSC_PER_MCYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins and status
    input wire logic count_input_a,
    input wire logic count_input_b,
    input wire logic gate_pin_a,
    input wire logic gate_pin_b,
    input wire logic unit_a_overflow_flag,
    input wire logic unit_b_overflow_flag,
    input wire logic mcyc_tick
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    logic [4:0] gap_q;
    logic [4:0] gap_d;
    logic ctl_wr;
    assign ctl_wr = reg_wr && reg_addr == DTC_ADDR_CTRL;
    always_comb gap_d = mcyc_tick ? 5'h00 : gap_q + 5'h01;
    always_ff @(posedge sys_clk) gap_q <= rst_n ? gap_d : 5'h00;
    // A flag may only drop through a software write of zero.
    sequence s_keep_a;
        unit_a_overflow_flag && !(ctl_wr && !reg_wdata[DTC_C_FLAG_A]);
    endsequence
    sequence s_keep_b;
        unit_b_overflow_flag && !(ctl_wr && !reg_wdata[DTC_C_FLAG_B]);
    endsequence
    AST_TICK_SPACING: assert property (mcyc_tick |-> gap_q == 5'(OSC_PER_MCYC - 1))
        else $error("machine tick came early");
    AST_TICK_DUE: assert property (gap_q == 5'(OSC_PER_MCYC - 1) |-> mcyc_tick)
        else $error("machine tick missing");
    AST_FLAG_A_KEEP: assert property (s_keep_a |=> unit_a_overflow_flag)
        else $error("unit a flag cleared by hardware");
    AST_FLAG_B_KEEP: assert property (s_keep_b |=> unit_b_overflow_flag)
        else $error("unit b flag cleared by hardware");
    AST_FLAG_A_CAUSE: assert property (!unit_a_overflow_flag && !ctl_wr && !mcyc_tick
        |=> !unit_a_overflow_flag)
        else $error("unit a flag set off a tick");
    AST_FLAG_B_CAUSE: assert property (!unit_b_overflow_flag && !ctl_wr && !mcyc_tick
        |=> !unit_b_overflow_flag)
        else $error("unit b flag set off a tick");
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    AST_RD_UNMAPPED: assert property (reg_rd && (reg_addr < 8'h88 || reg_addr > 8'h8d)
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // dtc_monitor

/* File: bench/dtc_pin_model.sv */
// Model of the external count and gate pins that face the dual timer.
module dtc_pin_model #(
    parameter int HOLD = 8
) (
    // Clock
    input wire logic sys_clk,
    // Pins towards the timer
    output logic count_input_a,
    output logic count_input_b,
    output logic gate_pin_a,
    output logic gate_pin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // Count pins rest high at their pull-up; gates start closed.
    initial begin
        count_input_a = 1'b1;
        count_input_b = 1'b1;
        gate_pin_a = 1'b0;
        gate_pin_b = 1'b0;
    end
    task automatic edges(input logic unit_b, input int n);
        repeat (n) begin
            @(posedge sys_clk);
            if (unit_b) count_input_b <= 1'b0;
            else count_input_a <= 1'b0;
            repeat (HOLD) @(posedge sys_clk);
            if (unit_b) count_input_b <= 1'b1;
            else count_input_a <= 1'b1;
            repeat (HOLD - 1) @(posedge sys_clk);
        end
    endtask
    task automatic set_gate(input logic unit_b, input logic level);
        @(posedge sys_clk);
        if (unit_b) gate_pin_b <= level;
        else gate_pin_a <= level;
    endtask
endmodule // dtc_pin_model

/* File: bench/dtc_timer_bench.sv */
// Self-checking bench of the dual four-mode timer with its pin model.
module dtc_timer_bench
    import dtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OSC = 4;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic count_input_a, count_input_b, gate_pin_a, gate_pin_b;
    logic unit_a_overflow_flag, unit_b_overflow_flag, mcyc_tick;
    int mismatches = 0;
    int compares = 0;
    int ticks = 0;
    int cycles = 0;
    dtc_timer #(.OSC_PER_MCYC(OSC)) dtc_timer_inst (.*);
    dtc_pin_model #(.HOLD(2 * OSC)) dtc_pin_model_inst (.*);
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // A hang ends the run as a failure instead of stalling the simulator.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        ticks <= ticks + int'(mcyc_tick === 1'b1);
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        cmp(what, exp, reg_rdata);
    endtask
    task automatic wait_ticks(input int n);
        int t;
        t = ticks;
        wait (ticks == t + n);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] addrs [7] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h90};
        int c;
        foreach (addrs[i]) rd_chk("reset value", addrs[i], 8'h00);
        wait_ticks(1);
        c = cycles;
        wait_ticks(1);
        cmp("tick spacing", 8'(OSC), 8'(cycles - c));
        wr(DTC_ADDR_MODE, 8'ha5);
        rd_chk("mode", DTC_ADDR_MODE, 8'ha5);
        wr(8'h90, 8'hff);
        rd_chk("unmapped", 8'h90, 8'h00);
        $display("test reset done");
    endtask
    // Bytes are loaded while stopped; three ticks run, the second one wraps.
    task automatic t_run(input string what, input logic [7:0] mode, input logic unit_b,
        input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] elo, input logic [7:0] ehi);
        logic [7:0] la;
        logic [7:0] ha;
        logic [7:0] run;
        logic [7:0] pins;
        la = unit_b ? DTC_ADDR_B_LOW : DTC_ADDR_A_LOW;
        ha = unit_b ? DTC_ADDR_B_HIGH : DTC_ADDR_A_HIGH;
        run = unit_b ? 8'h40 : 8'h10;
        wr(DTC_ADDR_CTRL, 8'h00);
        wr(DTC_ADDR_MODE, mode);
        wr(la, lo);
        wr(ha, hi);
        wait_ticks(1);
        wr(DTC_ADDR_CTRL, run);
        wait_ticks(2);
        rd_chk("flag", DTC_ADDR_CTRL, run | (run << 1));
        pins = {unit_b_overflow_flag, 1'b0, unit_a_overflow_flag, 5'h00};
        cmp("flag pins", run << 1, pins);
        wait_ticks(1);
        wr(DTC_ADDR_CTRL, 8'h00);
        rd_chk("low", la, elo);
        rd_chk("high", ha, ehi);
        $display("test %s done", what);
    endtask
    task automatic t_split();
        wr(DTC_ADDR_CTRL, 8'h00);
        wr(DTC_ADDR_MODE, 8'h33);
        wr(DTC_ADDR_A_LOW, 8'hfe);
        wr(DTC_ADDR_A_HIGH, 8'hfd);
        wr(DTC_ADDR_B_LOW, 8'h55);
        wait_ticks(1);
        wr(DTC_ADDR_CTRL, 8'h50);
        wait_ticks(2);
        rd_chk("split flags", DTC_ADDR_CTRL, 8'h70);
        wait_ticks(1);
        // Stop before the next tick, so the flags are read from the pins.
        @(posedge sys_clk);
        cmp("split pins", 8'h03, {6'h00, unit_b_overflow_flag, unit_a_overflow_flag});
        wr(DTC_ADDR_CTRL, 8'h00);
        rd_chk("split flags", DTC_ADDR_CTRL, 8'h00);
        rd_chk("split low", DTC_ADDR_A_LOW, 8'h01);
        rd_chk("split high", DTC_ADDR_A_HIGH, 8'h00);
        rd_chk("held count", DTC_ADDR_B_LOW, 8'h55);
        // Unit B leaves mode 3 and counts again, but its wrap raises no flag.
        wr(DTC_ADDR_MODE, 8'h13);
        wr(DTC_ADDR_B_LOW, 8'hff);
        wr(DTC_ADDR_B_HIGH, 8'hff);
        wait_ticks(1);
        wr(DTC_ADDR_CTRL, 8'h40);
        wait_ticks(1);
        rd_chk("no unit b flag", DTC_ADDR_CTRL, 8'h40);
        wr(DTC_ADDR_CTRL, 8'h00);
        rd_chk("unit b low", DTC_ADDR_B_LOW, 8'h01);
        rd_chk("unit b high", DTC_ADDR_B_HIGH, 8'h00);
        $display("test split done");
    endtask
    // Edges with the gate closed must not count; three with it open must.
    task automatic t_count(input logic unit_b);
        wr(DTC_ADDR_CTRL, 8'h00);
        wr(DTC_ADDR_MODE, unit_b ? 8'hd0 : 8'h0d);
        wr(unit_b ? DTC_ADDR_B_LOW : DTC_ADDR_A_LOW, 8'h00);
        wr(DTC_ADDR_CTRL, unit_b ? 8'h40 : 8'h10);
        dtc_pin_model_inst.edges(unit_b, 2);
        dtc_pin_model_inst.set_gate(unit_b, 1'b1);
        dtc_pin_model_inst.edges(unit_b, 3);
        dtc_pin_model_inst.set_gate(unit_b, 1'b0);
        wr(DTC_ADDR_CTRL, 8'h00);
        rd_chk("edge count", unit_b ? DTC_ADDR_B_LOW : DTC_ADDR_A_LOW, 8'h03);
        $display("test count done");
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_run("mode1", 8'h01, 1'b0, 8'hfe, 8'hff, 8'h01, 8'h00);
        t_run("mode0", 8'h00, 1'b1, 8'hfe, 8'hff, 8'he1, 8'h00);
        t_run("mode2", 8'h02, 1'b0, 8'hfe, 8'h80, 8'h81, 8'h80);
        t_run("mode0 a", 8'h00, 1'b0, 8'hfe, 8'hff, 8'he1, 8'h00);
        t_run("mode2 b", 8'h20, 1'b1, 8'hfe, 8'h80, 8'h81, 8'h80);
        t_split();
        t_count(1'b0);
        t_count(1'b1);
        final_report();
    end
endmodule // dtc_timer_bench
bind dtc_timer dtc_monitor #(.OSC_PER_MCYC(OSC_PER_MCYC)) dtc_monitor_inst (.*);
